// >>> emb_pkg.sv
package emb_pkg;
  localparam logic [11:0] ADDR_POWER_CONTROL = 12'h87 << 2;
  localparam logic [11:0] ADDR_BUS_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_BUS_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_ADDRESS       = 12'h008;
  localparam logic [11:0] ADDR_PORT_LATCH    = 12'h00c;
  localparam int          PC_IDLE_BIT        = 0;
  localparam int          PC_PDOWN_BIT       = 1;
  localparam int          PC_ALE_DIS_BIT     = 5;
  localparam logic [7:0]  PC_RESET           = 8'h00;
  localparam int          SLOT_PERIODS       = 6;
  localparam int          CYCLE_PERIODS      = 12;
  localparam int          RESET_CYCLES       = 2;
  // Control register bits: start access, kind of access, wake enable, table access.
  localparam int          CT_GO_BIT          = 0;
  localparam int          CT_IND_BIT         = 1;
  localparam int          CT_WAKE_EN_BIT     = 2;
  localparam int          CT_TABLE_BIT       = 3;
  localparam logic [7:0]  PORT_RESET         = 8'hff;

  typedef enum logic [1:0] {
    EMB_RUN   = 2'b00,
    EMB_IDLE  = 2'b01,
    EMB_PDOWN = 2'b11,
    EMB_WAKE  = 2'b10
  } emb_mode_e;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } emb_pins_s;
endpackage

// >>> emb_top.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module emb_top (
  input  wire logic              pclk,       // System clock, oscillator rate.
  input  wire logic              presetn,    // Async reset, active low.
  input  wire logic              psel,       // APB select.
  input  wire logic              penable,    // APB access phase.
  input  wire logic              pwrite,     // APB direction.
  input  wire logic [11:0]       paddr,      // APB byte address.
  input  wire logic [31:0]       pwdata,     // APB write data.
  output logic      [31:0]       prdata,     // APB read data.
  output logic                   pready,     // APB ready.
  output logic                   pslverr,    // APB error.
  input  wire logic              rst_pin,    // Reset pin, active high.
  input  wire logic              external_fetch_select, // Strap, low = ext.
  input  wire logic              ext_irq_zero_n, // Wake input, low active.
  input  wire logic              ext_irq_one_n,  // Wake input, low active.
  input  wire logic [7:0]        p0_i,       // Port 0 pin levels.
  output emb_pkg::emb_pins_s     p0_pins,    // Port 0 drive and enables.
  output emb_pkg::emb_pins_s     p2_pins,    // Port 2 drive and enables.
  output logic                   addr_strobe,     // Address latch strobe.
  output logic                   addr_strobe_oe,  // Strobe hard drive.
  output logic                   addr_strobe_pu,  // Weak pull-up on strobe.
  output logic                   program_fetch_strobe_n, // Fetch, low act.
  output logic                   core_reset,  // Reset to the core.
  output logic                   osc_run,     // Oscillator enable.
  output logic                   exec_enable  // Core may execute.
);
  import emb_pkg::*;

  logic [3:0]  div_cnt;
  logic        slot_tick;
  logic        cycle_tick;
  logic        half;
  logic [3:0]  rst_cnt;
  logic        ext_mode;
  logic [7:0]  power_control_reg;
  logic [7:0]  upper_port_latch;
  logic [7:0]  p0_latch;
  logic [15:0] access_addr;
  logic [3:0]  ctrl;
  logic        xfer;
  logic        skip_ale;
  logic [1:0]  skip_fetch;
  emb_mode_e   mode;
  emb_mode_e   next_mode;
  logic        wr_en;
  logic        rd_en;
  logic        wake_lvl;
  logic        ale_disabled;
  logic        in_low_power;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a[11:2] == r[11:2]);
  endfunction

  // Divide the oscillator into six-period slots and twelve-period cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 4'h0;
    end else if (osc_run) begin
      div_cnt <= (div_cnt == 4'(CYCLE_PERIODS - 1)) ? 4'h0 : div_cnt + 4'h1;
    end
  end
  assign half       = (div_cnt >= 4'(SLOT_PERIODS));
  assign slot_tick  = osc_run && (div_cnt == 4'(SLOT_PERIODS - 1) ||
                                  div_cnt == 4'(CYCLE_PERIODS - 1));
  assign cycle_tick = osc_run && (div_cnt == 4'(CYCLE_PERIODS - 1));

  // Reset pin qualified over two machine cycles; oscillator must run.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt    <= 4'h0;
      core_reset <= 1'b1;
    end else if (!rst_pin) begin
      rst_cnt    <= 4'h0;
      core_reset <= 1'b0;
    end else if (cycle_tick) begin
      if (rst_cnt >= 4'(RESET_CYCLES - 1)) begin
        core_reset <= 1'b1;
      end else begin
        rst_cnt <= rst_cnt + 4'h1;
      end
    end
  end

  // Strap taken while reset is asserted; a clocked capture, not async.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode <= 1'b0;
    end else if (core_reset) begin
      ext_mode <= !external_fetch_select;
    end
  end

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Power control register; reset reloads it, which ends the strobe disable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_reg <= PC_RESET;
    end else if (core_reset) begin
      power_control_reg <= PC_RESET;
    end else if (mode == EMB_WAKE) begin
      // Wake completes: mode bits drop, disable bit kept.
      // Cleared for the whole wake state, so a short wake level still ends
      // power-down instead of falling back into it.
      power_control_reg[PC_IDLE_BIT]  <= 1'b0;
      power_control_reg[PC_PDOWN_BIT] <= 1'b0;
    end else if (mode == EMB_IDLE && ctrl[CT_WAKE_EN_BIT] &&
                 (!ext_irq_zero_n || !ext_irq_one_n)) begin
      power_control_reg[PC_IDLE_BIT] <= 1'b0;
    end else if (wr_en && hit(paddr, ADDR_POWER_CONTROL) && mode == EMB_RUN) begin
      power_control_reg <= pwdata[7:0];
    end
  end

  // Wake level: either enabled interrupt line held low.
  assign wake_lvl = ctrl[CT_WAKE_EN_BIT] && (!ext_irq_zero_n || !ext_irq_one_n);

  always_comb begin
    next_mode = mode;
    case (mode)
      EMB_RUN: begin
        if (power_control_reg[PC_PDOWN_BIT]) next_mode = EMB_PDOWN;
        else if (power_control_reg[PC_IDLE_BIT]) next_mode = EMB_IDLE;
      end
      EMB_IDLE:  if (!power_control_reg[PC_IDLE_BIT]) next_mode = EMB_RUN;
      EMB_PDOWN: if (wake_lvl) next_mode = EMB_WAKE;
      EMB_WAKE:  if (!wake_lvl) next_mode = EMB_RUN;
      default:   next_mode = EMB_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= EMB_RUN;
    end else if (core_reset) begin
      mode <= EMB_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign in_low_power = (mode != EMB_RUN);

  // Oscillator stops in power-down; a held wake level restarts it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run     <= 1'b1;
      exec_enable <= 1'b1;
    end else begin
      osc_run     <= !(next_mode == EMB_PDOWN) || rst_pin;
      exec_enable <= (next_mode == EMB_RUN) && !core_reset;
    end
  end

  // Software latches and the external access request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_port_latch <= PORT_RESET;
      p0_latch         <= PORT_RESET;
      access_addr      <= 16'h0000;
      ctrl             <= 4'h0;
    end else if (core_reset) begin
      upper_port_latch <= PORT_RESET;
      p0_latch         <= PORT_RESET;
      ctrl             <= 4'h0;
    end else begin
      if (cycle_tick && xfer) begin
        ctrl[CT_GO_BIT] <= 1'b0;
      end
      if (wr_en && hit(paddr, ADDR_PORT_LATCH)) begin
        upper_port_latch <= pwdata[15:8];
        p0_latch         <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, ADDR_ADDRESS)) access_addr <= pwdata[15:0];
      if (wr_en && hit(paddr, ADDR_BUS_CTRL) && !in_low_power) begin
        ctrl <= pwdata[3:0];
      end
    end
  end

  // An external data access spans one machine cycle, claimed at its start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer       <= 1'b0;
      skip_ale   <= 1'b0;
      skip_fetch <= 2'b00;
    end else if (core_reset || in_low_power) begin
      xfer       <= 1'b0;
      skip_ale   <= 1'b0;
      skip_fetch <= 2'b00;
    end else if (cycle_tick) begin
      xfer       <= ctrl[CT_GO_BIT] && !xfer && !ctrl[CT_TABLE_BIT];
      skip_ale   <= ctrl[CT_GO_BIT] && !xfer && !ctrl[CT_TABLE_BIT];
      skip_fetch <= (ctrl[CT_GO_BIT] && !xfer && !ctrl[CT_TABLE_BIT]) ?
                    2'b11 : 2'b00;
    end else if (slot_tick) begin
      skip_ale   <= 1'b0;
      skip_fetch <= {1'b0, skip_fetch[1]};
    end
  end

  assign ale_disabled = power_control_reg[PC_ALE_DIS_BIT] && !ext_mode
                        && !xfer && !ctrl[CT_TABLE_BIT];

  // Strobes: in run mode the strobe is high in the first period of each slot unless skipped or disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_strobe            <= 1'b0;
      addr_strobe_oe         <= 1'b1;
      addr_strobe_pu         <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
    end else if (mode == EMB_IDLE) begin
      addr_strobe            <= 1'b1;
      addr_strobe_oe         <= 1'b1;
      addr_strobe_pu         <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
    end else if (mode == EMB_PDOWN || mode == EMB_WAKE) begin
      addr_strobe            <= 1'b0;
      addr_strobe_oe         <= 1'b1;
      addr_strobe_pu         <= 1'b0;
      program_fetch_strobe_n <= 1'b0;
    end else begin
      addr_strobe    <= !ale_disabled && !skip_ale &&
                        (div_cnt == 4'h0 || div_cnt == 4'(SLOT_PERIODS));
      addr_strobe_oe <= !ale_disabled;
      addr_strobe_pu <= ale_disabled;
      program_fetch_strobe_n <= !(ext_mode && !skip_fetch[0] &&
                        (div_cnt == 4'd3 || div_cnt == 4'd9));
    end
  end

  // Port 0 bus role and port 2 address byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_pins <= '{o: 8'h00, oe: 8'h00};
      p2_pins <= '{o: PORT_RESET, oe: PORT_RESET};
    end else if (ext_mode && in_low_power) begin
      p0_pins <= '{o: 8'h00, oe: 8'h00};
      p2_pins <= (mode == EMB_IDLE) ?
                 '{o: access_addr[15:8], oe: 8'hff} :
                 '{o: upper_port_latch, oe: 8'hff};
    end else if (ext_mode || xfer) begin
      p0_pins <= '{o: access_addr[7:0], oe: 8'hff};
      p2_pins <= (xfer && ctrl[CT_IND_BIT]) ?
                 '{o: upper_port_latch, oe: 8'hff} :
                 '{o: access_addr[15:8], oe: 8'hff};
    end else begin
      p0_pins <= '{o: 8'h00, oe: ~p0_latch};
      p2_pins <= '{o: upper_port_latch, oe: 8'hff};
    end
  end

  // APB slave: zero wait states, error on unmapped offsets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hit(paddr, ADDR_POWER_CONTROL) ||
                 hit(paddr, ADDR_BUS_CTRL) || hit(paddr, ADDR_BUS_STATUS) ||
                 hit(paddr, ADDR_ADDRESS) || hit(paddr, ADDR_PORT_LATCH));
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, ADDR_POWER_CONTROL)) prdata <= {24'h0, power_control_reg};
        else if (hit(paddr, ADDR_BUS_CTRL)) prdata <= {28'h0, ctrl};
        else if (hit(paddr, ADDR_BUS_STATUS))
          prdata <= {24'h0, p0_i[0], 1'b0, mode, xfer, ext_mode,
                     addr_strobe_pu, core_reset};
        else if (hit(paddr, ADDR_ADDRESS)) prdata <= {16'h0, access_addr};
        else if (hit(paddr, ADDR_PORT_LATCH))
          prdata <= {16'h0, upper_port_latch, p0_i};
        else prdata <= 32'h0000_0000;
      end
    end
  end

  power_down_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == EMB_PDOWN && !rst_pin && !wake_lvl) |=> !osc_run)
    else $error("oscillator runs in power-down");
  idle_strobes_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(mode) == EMB_IDLE && mode == EMB_IDLE |->
    addr_strobe && program_fetch_strobe_n)
    else $error("strobes not high in idle");
  ext_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_mode |-> !ale_disabled)
    else $error("strobe disabled in external mode");
  reset_cancel_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_reset |=> !power_control_reg[PC_ALE_DIS_BIT])
    else $error("reset kept strobe disable");
  pullup_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(addr_strobe_pu && addr_strobe_oe))
    else $error("pull-up and drive together");
  strobe_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    (addr_strobe && mode == EMB_RUN && !xfer && osc_run && !ale_disabled)
    |-> ##6 (addr_strobe || skip_ale || mode != EMB_RUN || !osc_run ||
             ale_disabled))
    else $error("strobe rate not one sixth");
  fetch_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    (skip_fetch[0] && mode == EMB_RUN) |=> program_fetch_strobe_n)
    else $error("fetch strobe not skipped");
  wake_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == EMB_WAKE && !wake_lvl && !core_reset) |=> mode == EMB_RUN)
    else $error("wake did not complete");
endmodule // emb_top
`default_nettype wire

// >>> emb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model
  import emb_pkg::*;
(
  input  wire logic      pclk,    // Oscillator clock.
  input  wire logic      strobe,  // Address latch strobe.
  input  wire logic      fetch_n, // Program fetch, low active.
  input  wire emb_pins_s p0,      // Port 0 drive.
  input  wire emb_pins_s p2,      // Port 2 drive.
  output logic [7:0]     p0_i,    // Port 0 wire level.
  output logic [15:0]    addr_q   // Latched address.
);
  logic [7:0] junk = 8'h5a;
  logic [7:0] rom;

  // A floating port 0 has no pull-up, so an undriven pin must not look stable.
  always @(posedge pclk) junk <= ~junk;
  always @(negedge strobe) addr_q <= {p2.o, p0.o};
  assign rom = addr_q[7:0] ^ addr_q[15:8];
  // The memory answers only while the fetch strobe is low.
  assign p0_i = (p0.oe & p0.o) | (~p0.oe & (fetch_n ? junk : rom));
endmodule // emb_mem_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import emb_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rst_pin = 1'b0, strap = 1'b1;
  logic irq0_n = 1'b1, irq1_n = 1'b1, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  p0_i, latch_v;
  logic [15:0] addr_v;
  emb_pins_s   p0_pins, p2_pins;
  logic        strobe, s_oe, s_pu, fetch_n, core_reset, osc_run, exec_en;
  logic        seen, ind_ok;
  int          n_fail = 0, checks_done = 0, ale, fet;

  always #5 pclk = ~pclk;

  emb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rst_pin(rst_pin),
    .external_fetch_select(strap), .ext_irq_zero_n(irq0_n),
    .ext_irq_one_n(irq1_n), .p0_i(p0_i), .p0_pins(p0_pins),
    .p2_pins(p2_pins), .addr_strobe(strobe), .addr_strobe_oe(s_oe),
    .addr_strobe_pu(s_pu), .program_fetch_strobe_n(fetch_n),
    .core_reset(core_reset), .osc_run(osc_run), .exec_enable(exec_en));

  emb_mem_model mem (.pclk(pclk), .strobe(strobe), .fetch_n(fetch_n),
    .p0(p0_pins), .p2(p2_pins), .p0_i(p0_i), .addr_q());

  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      n_fail++;
      test_done();
    end
  endtask

  // Selector: 0 core reset, 1 execute enable, 2 oscillator run.
  task wait_lvl(input int sel, input logic lvl);
    for (int k = 0; k < 4000; k++) begin
      @(posedge pclk);
      if ((sel == 0 ? core_reset : sel == 1 ? exec_en : osc_run) === lvl)
        return;
    end
    n_fail++;
    test_done();
  endtask

  task count(input int n);
    logic pa, pf;
    ale = 0;
    fet = 0;
    seen = 1'b0;
    ind_ok = 1'b1;
    pa = strobe;
    pf = fetch_n;
    repeat (n) begin
      @(posedge pclk);
      ale += int'(strobe === 1'b1 && pa === 1'b0);
      fet += int'(fetch_n === 1'b0 && pf === 1'b1);
      seen |= (p2_pins.o === addr_v[15:8]);
      ind_ok &= (p2_pins.o === latch_v);
      pa = strobe;
      pf = fetch_n;
    end
  endtask

  task pin_reset(input logic s);
    strap <= s;
    rst_pin <= 1'b1;
    repeat (30) @(posedge pclk);
    check("core_reset", core_reset, 1);
    rst_pin <= 1'b0;
    wait_lvl(0, 1'b0);
  endtask

  initial begin
    void'($urandom(52));
    latch_v = 8'($urandom);
    addr_v = {~latch_v, 8'($urandom)};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_lvl(0, 1'b0);
    apb(ADDR_POWER_CONTROL, 1'b0, 32'h0);
    check("pc reset", rd, {24'h0, PC_RESET});
    apb(12'h100, 1'b0, 32'h0);
    check("unmapped", err, 1);
    apb(ADDR_PORT_LATCH, 1'b1, {16'h0, latch_v, 8'hff});
    apb(ADDR_PORT_LATCH, 1'b0, 32'h0);
    check("p2 latch", rd[15:8], latch_v);
    check("p0 float", p0_pins.oe, 8'h00);
    apb(ADDR_ADDRESS, 1'b1, {16'h0, addr_v});
    apb(ADDR_ADDRESS, 1'b0, 32'h0);
    check("address", rd, {16'h0, addr_v});
    $display("test registers done");
    count(120);
    check("ale rate", ale, 20);
    check("no fetch", fet, 0);
    apb(ADDR_BUS_CTRL, 1'b1, 32'h1);
    count(48);
    check("ale skip", ale, 7);
    check("p2 addr", seen, 1);
    apb(ADDR_BUS_CTRL, 1'b1, 32'h3);
    count(48);
    check("p2 ind", ind_ok, 1);
    check("ale skip i", ale, 7);
    $display("test internal access done");
    pin_reset(1'b0);
    count(120);
    check("ext ale", ale, 20);
    check("ext fetch", fet, 20);
    apb(ADDR_POWER_CONTROL, 1'b1, 32'h20);
    count(120);
    check("ext dis", ale, 20);
    check("ext pu", s_pu, 0);
    apb(ADDR_BUS_CTRL, 1'b1, 32'h1);
    count(48);
    check("fetch skip", fet, 6);
    check("ale skip e", ale, 7);
    pin_reset(1'b1);
    // Reset reloads the port latches, so the later port checks need them back.
    apb(ADDR_PORT_LATCH, 1'b1, {16'h0, latch_v, 8'hff});
    apb(ADDR_POWER_CONTROL, 1'b0, 32'h0);
    check("pc cleared", rd, 32'h0);
    check("pu cleared", s_pu, 0);
    $display("test external done");
    apb(ADDR_POWER_CONTROL, 1'b1, 32'h20);
    count(48);
    check("dis ale", ale, 0);
    check("dis pu", {s_oe, s_pu}, 2'b01);
    apb(ADDR_BUS_CTRL, 1'b1, 32'h9);
    count(48);
    check("table ale", ale > 0, 1);
    apb(ADDR_BUS_CTRL, 1'b1, 32'h4);
    apb(ADDR_POWER_CONTROL, 1'b1, 32'h21);
    repeat (24) @(posedge pclk);
    check("idle pins", {strobe, fetch_n, s_pu}, 3'b110);
    check("idle exec", exec_en, 0);
    check("idle p2", p2_pins.o, latch_v);
    irq0_n <= 1'b0;
    wait_lvl(1, 1'b1);
    irq0_n <= 1'b1;
    apb(ADDR_POWER_CONTROL, 1'b0, 32'h0);
    check("idle kept", rd, 32'h20);
    $display("test idle done");
    apb(ADDR_POWER_CONTROL, 1'b1, 32'h22);
    repeat (24) @(posedge pclk);
    check("pd pins", {strobe, fetch_n, s_pu}, 3'b000);
    check("pd osc", osc_run, 0);
    irq1_n <= 1'b0;
    wait_lvl(2, 1'b1);
    check("pd held", exec_en, 0);
    irq1_n <= 1'b1;
    wait_lvl(1, 1'b1);
    apb(ADDR_POWER_CONTROL, 1'b0, 32'h0);
    check("pd kept", rd, 32'h20);
    apb(ADDR_PORT_LATCH, 1'b0, 32'h0);
    check("pd latch", rd[15:8], latch_v);
    pin_reset(1'b1);
    apb(ADDR_POWER_CONTROL, 1'b0, 32'h0);
    check("rst pc", rd, 32'h0);
    $display("test power down done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
